// ---- logic/rcq_pkg.sv ----
// shared constants and types for the redriver configuration and equalization control
// Notes on behaviour
// - Link state comes only from termination, idle, periodic signals and rate, not traffic.
// - Pairs are probed repeatedly; a found far-end receiver enables termination and forwarding.
// - Equalization of an input is turned off whenever periodic signalling is sensed on it.
// - Without periodic signalling, gain comes from straps, or written values in register mode.
// - Both mux-side receive ports and the system-side transmit input get their own equalizer.
// - Each strap input is decoded as low, resistor-to-ground, floating or high.
// - Four-level straps cover bus enable and both equalizer pin pairs, setting gain and mode.
// - All straps are captured just after internal reset rises and used from then on.
// - After the hold interval the strap bias resistors are disconnected.
// - Each path takes two four-level straps, for sixteen settings per path.
// - Levels map to codes 00, 01, 10, 11; a setting is the upper pin's code then the lower's.
package rcq_pkg;
   // ==========================================================
   // strap levels
   localparam logic [1:0] LVL_LOW   = 2'h0;
   localparam logic [1:0] LVL_RES   = 2'h1;
   localparam logic [1:0] LVL_FLOAT = 2'h2;
   localparam logic [1:0] LVL_HIGH  = 2'h3;
   localparam int EQ_W     = 4;
   localparam int NUM_CH   = 3;
   localparam int CH_RX1   = 0;
   localparam int CH_RX2   = 1;
   localparam int CH_SSTX  = 2;
   // ==========================================================
   // timing
   localparam int CLK_MHZ          = 200;
   localparam int HOLD_US          = 10;
   localparam int HOLD_CYC         = HOLD_US * CLK_MHZ;
   localparam int RXDET_INTV_MS    = 12;
   localparam int RXDET_INTV_CYC   = RXDET_INTV_MS * 1000 * CLK_MHZ;
   localparam int CNT_W            = 22;
   localparam int DET_PULSE_CYC    = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 22'h0;
   localparam logic [CNT_W-1:0] CNT_ONE  = 22'h1;

   typedef enum logic [1:0] {
      RCQ_LNK_DISC,
      RCQ_LNK_U0,
      RCQ_LNK_U1,
      RCQ_LNK_U23
   } rcq_link_t;

   typedef enum logic [1:0] {
      RCQ_CFG_WAIT,
      RCQ_CFG_HOLD,
      RCQ_CFG_DONE
   } rcq_cfg_t;
endpackage

// ---- logic/rcq_eq_if.sv ----
// carrier of latched strap settings between the loader and the equalizer select
`timescale 1ns/1ps
interface rcq_eq_if;
   logic [3:0] rx_port_eq_setting;
   logic [3:0] sys_tx_eq_setting;
   logic       reg_mode;
   logic       valid;
   modport src (output rx_port_eq_setting, output sys_tx_eq_setting, output reg_mode,
                output valid);
   modport dst (input rx_port_eq_setting, input sys_tx_eq_setting, input reg_mode,
                input valid);
endinterface

// ---- logic/rcq_eq_sel.sv ----
// per-channel equalization select with periodic-signalling suspend
`timescale 1ns/1ps
module rcq_eq_sel (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   rcq_eq_if.dst            cfg,
   input  wire logic [3:0]  i_rx_port_one_eq_setting,
   input  wire logic [3:0]  i_rx_port_two_eq_setting,
   input  wire logic [3:0]  i_sys_tx_eq_setting,
   input  wire logic [2:0]  i_lfps_det,
   output logic      [11:0] o_eq_gain,
   output logic      [2:0]  o_eq_en
);
   typedef struct packed {
      logic [11:0] gain;
      logic [2:0]  en;
   } rcq_sel_st_t;

   rcq_sel_st_t s_q;
   rcq_sel_st_t s_d;
   logic [11:0] src;
   logic [11:0] gain_n;
   logic [2:0]  en_n;

   always_comb begin
      if (cfg.reg_mode) begin
         src = {i_sys_tx_eq_setting, i_rx_port_two_eq_setting, i_rx_port_one_eq_setting};
      end else begin
         src = {cfg.sys_tx_eq_setting, cfg.rx_port_eq_setting, cfg.rx_port_eq_setting};
      end
   end

   generate
      for (genvar c = 0; c < rcq_pkg::NUM_CH; c++) begin : g_ch
         assign gain_n[c*4 +: 4] = src[c*4 +: 4];
         // lfps wins: equalizer off while it is present
         assign en_n[c] = cfg.valid & ~i_lfps_det[c];
      end
   endgenerate

   always_comb begin
      s_d      = s_q;
      s_d.gain = gain_n;
      s_d.en   = en_n;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_eq_gain = s_q.gain;
   assign o_eq_en   = s_q.en;
endmodule

// ---- logic/rcq_top.sv ----
// strap loader, receiver detection and link state inference for the redriver
`timescale 1ns/1ps
module rcq_top #(
   parameter int HOLD_CYC_P  = rcq_pkg::HOLD_CYC,
   parameter int RXDET_CYC_P = rcq_pkg::RXDET_INTV_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   input  wire logic        i_int_reset_n,
   input  wire logic [1:0]  i_cfg_bus_en_strap,
   input  wire logic [3:0]  i_rx_port_eq_straps,
   input  wire logic [3:0]  i_sys_tx_eq_straps,
   input  wire logic [3:0]  i_rx_port_one_eq_setting,
   input  wire logic [3:0]  i_rx_port_two_eq_setting,
   input  wire logic [3:0]  i_sys_tx_eq_setting,
   input  wire logic [2:0]  i_lfps_det,
   input  wire logic [1:0]  i_far_term_det,
   input  wire logic [1:0]  i_elec_idle,
   input  wire logic        i_ss_rate,
   output logic             o_strap_bias_en,
   output logic             o_reg_mode,
   output logic [11:0]      o_eq_gain,
   output logic [2:0]       o_eq_en,
   output logic             o_rx_det_pulse,
   output logic             o_rx_term_en,
   output logic             o_fwd_ready,
   output logic [1:0]       o_link_state
);
   typedef struct packed {
      rcq_pkg::rcq_cfg_t  cfg;
      rcq_pkg::rcq_link_t lnk;
      logic               rst_seen;
      logic [21:0]        hold_cnt;
      logic [21:0]        det_cnt;
      logic [3:0]         rx_eq;
      logic [3:0]         ss_eq;
      logic               reg_mode;
      logic               bias_en;
      logic               det_pulse;
      logic               term_en;
      logic               fwd;
   } rcq_st_t;

   rcq_st_t  s_q;
   rcq_st_t  s_d;
   rcq_eq_if eq_if ();

   logic [rcq_pkg::CNT_W-1:0] hold_lim;
   logic [rcq_pkg::CNT_W-1:0] det_lim;
   logic                      both_term;
   logic                      any_lfps;

   assign hold_lim  = rcq_pkg::CNT_W'(HOLD_CYC_P);
   assign det_lim   = rcq_pkg::CNT_W'(RXDET_CYC_P);
   assign both_term = &i_far_term_det;
   assign any_lfps  = |i_lfps_det;

   // ==========================================================
   // next state
   always_comb begin
      s_d = s_q;
      s_d.det_pulse = 1'b0;
      // ------------------------------------------------------
      // strap capture: once per internal reset rise, then frozen
      unique case (s_q.cfg)
         rcq_pkg::RCQ_CFG_WAIT: begin
            s_d.bias_en = 1'b1;
            if (i_int_reset_n) begin
               // straps arrive already decoded as level codes
               s_d.rx_eq    = i_rx_port_eq_straps;
               s_d.ss_eq    = i_sys_tx_eq_straps;
               s_d.reg_mode = (i_cfg_bus_en_strap != rcq_pkg::LVL_LOW);
               s_d.hold_cnt = rcq_pkg::CNT_ZERO;
               s_d.cfg      = rcq_pkg::RCQ_CFG_HOLD;
            end
         end
         rcq_pkg::RCQ_CFG_HOLD: begin
            s_d.hold_cnt = s_q.hold_cnt + rcq_pkg::CNT_ONE;
            if (s_q.hold_cnt >= hold_lim - rcq_pkg::CNT_ONE) begin
               s_d.bias_en = 1'b0;
               s_d.cfg     = rcq_pkg::RCQ_CFG_DONE;
            end
         end
         rcq_pkg::RCQ_CFG_DONE: begin
            s_d.cfg = rcq_pkg::RCQ_CFG_DONE;
         end
         default: begin
            s_d.cfg = rcq_pkg::RCQ_CFG_WAIT;
         end
      endcase
      // internal reset low restarts the capture
      if (!i_int_reset_n) begin
         s_d.cfg     = rcq_pkg::RCQ_CFG_WAIT;
         s_d.bias_en = 1'b1;
      end
      // ------------------------------------------------------
      // periodic receiver detection while disconnected or parked
      if (s_q.lnk == rcq_pkg::RCQ_LNK_DISC || s_q.lnk == rcq_pkg::RCQ_LNK_U23) begin
         if (s_q.det_cnt >= det_lim - rcq_pkg::CNT_ONE) begin
            s_d.det_cnt   = rcq_pkg::CNT_ZERO;
            s_d.det_pulse = 1'b1;
         end else begin
            s_d.det_cnt = s_q.det_cnt + rcq_pkg::CNT_ONE;
         end
      end else begin
         s_d.det_cnt = rcq_pkg::CNT_ZERO;
      end
      // ------------------------------------------------------
      // link state from physical conditions only
      unique case (s_q.lnk)
         rcq_pkg::RCQ_LNK_DISC: begin
            if (s_q.det_pulse && both_term) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_U0;
            end
         end
         rcq_pkg::RCQ_LNK_U0: begin
            if (&i_elec_idle) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_U1;
            end
         end
         rcq_pkg::RCQ_LNK_U1: begin
            if (!(&i_elec_idle) && i_ss_rate) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_U0;
            end else if (any_lfps) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_U0;
            end else if (!i_ss_rate) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_U23;
            end
         end
         rcq_pkg::RCQ_LNK_U23: begin
            if (s_q.det_pulse && !both_term) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_DISC;
            end else if (any_lfps) begin
               s_d.lnk = rcq_pkg::RCQ_LNK_U0;
            end
         end
      endcase
      // drop the link in the same cycle that the bias comes back
      if (s_q.cfg != rcq_pkg::RCQ_CFG_DONE || !i_int_reset_n) begin
         s_d.lnk = rcq_pkg::RCQ_LNK_DISC;
      end
      // termination held on in every state but disconnect
      s_d.term_en = (s_d.lnk != rcq_pkg::RCQ_LNK_DISC);
      s_d.fwd     = (s_d.lnk == rcq_pkg::RCQ_LNK_U0);
   end

   // ==========================================================
   // state register
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '{cfg: rcq_pkg::RCQ_CFG_WAIT, lnk: rcq_pkg::RCQ_LNK_DISC, bias_en: 1'b1,
                  default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // equalizer selection
   assign eq_if.rx_port_eq_setting = s_q.rx_eq;
   assign eq_if.sys_tx_eq_setting  = s_q.ss_eq;
   assign eq_if.reg_mode           = s_q.reg_mode;
   assign eq_if.valid              = (s_q.cfg != rcq_pkg::RCQ_CFG_WAIT);

   rcq_eq_sel u_eq_sel (
      .i_clk                    (i_clk),
      .i_rstn                   (i_rstn),
      .cfg                      (eq_if),
      .i_rx_port_one_eq_setting (i_rx_port_one_eq_setting),
      .i_rx_port_two_eq_setting (i_rx_port_two_eq_setting),
      .i_sys_tx_eq_setting      (i_sys_tx_eq_setting),
      .i_lfps_det               (i_lfps_det),
      .o_eq_gain                (o_eq_gain),
      .o_eq_en                  (o_eq_en)
   );

   assign o_strap_bias_en = s_q.bias_en;
   assign o_reg_mode      = s_q.reg_mode;
   assign o_rx_det_pulse  = s_q.det_pulse;
   assign o_rx_term_en    = s_q.term_en;
   assign o_fwd_ready     = s_q.fwd;
   assign o_link_state    = s_q.lnk;
endmodule

// ---- verif/rcq_top_monitor.sv ----
// checker bound to the redriver control top
`timescale 1ns/1ps
module rcq_top_monitor #(
   parameter int HOLD_CYC_P = 8
) (
   input wire logic       i_clk,
   input wire logic       i_rstn,
   input wire logic       i_int_reset_n,
   input wire logic [2:0] i_lfps_det,
   input wire logic       o_strap_bias_en,
   input wire logic       o_reg_mode,
   input wire logic [2:0] o_eq_en,
   input wire logic       o_rx_det_pulse,
   input wire logic [1:0] o_link_state
);
   // ==========
   // bias run length: a hold counter off by one cycle shows here
   logic [15:0] run_q;
   always_ff @(posedge i_clk or negedge i_rstn)
      if (!i_rstn) run_q <= 16'h0;
      else run_q <= (o_strap_bias_en && i_int_reset_n) ? run_q + 16'h1 : 16'h0;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_set; (i_int_reset_n && !o_strap_bias_en) [*4]; endsequence
   sequence s_quiet; $past(i_lfps_det) == 3'h0; endsequence
   property p_lfps; (o_eq_en & $past(i_lfps_det)) == 3'h0; endproperty
   property p_eq_on; s_set ##0 s_quiet |-> o_eq_en == 3'h7; endproperty
   property p_fall; $fell(o_strap_bias_en) |-> run_q >= HOLD_CYC_P + 1; endproperty
   property p_late; o_strap_bias_en |-> run_q <= HOLD_CYC_P; endproperty
   property p_stay; !o_strap_bias_en && i_int_reset_n |=> !o_strap_bias_en; endproperty
   property p_mode; s_set |=> $stable(o_reg_mode); endproperty
   property p_pulse; o_rx_det_pulse |=> !o_rx_det_pulse [*8]; endproperty
   property p_link; o_strap_bias_en |-> o_link_state == 2'h0; endproperty
   a_lfps: assert property (p_lfps) else $error("eq on under lfps");
   a_eq_on: assert property (p_eq_on) else $error("eq off without lfps");
   a_fall: assert property (p_fall) else $error("bias dropped early");
   a_late: assert property (p_late) else $error("bias held too long");
   a_stay: assert property (p_stay) else $error("bias came back");
   a_mode: assert property (p_mode) else $error("mode changed");
   a_pulse: assert property (p_pulse) else $error("detect pulse too long");
   a_link: assert property (p_link) else $error("link before release");
endmodule
bind rcq_top rcq_top_monitor #(.HOLD_CYC_P(HOLD_CYC_P)) u_mon (
   .i_clk           (i_clk),
   .i_rstn          (i_rstn),
   .i_int_reset_n   (i_int_reset_n),
   .i_lfps_det      (i_lfps_det),
   .o_strap_bias_en (o_strap_bias_en),
   .o_reg_mode      (o_reg_mode),
   .o_eq_en         (o_eq_en),
   .o_rx_det_pulse  (o_rx_det_pulse),
   .o_link_state    (o_link_state)
);

// ---- verif/rcq_far_end.sv ----
// far-end model: receiver terminations and idle signalling
`timescale 1ns/1ps
module rcq_far_end (
   input  wire logic       i_clk,
   input  wire logic       i_pulse,
   input  wire logic       i_present,
   input  wire logic       i_idle,
   output logic      [1:0] o_term,
   output logic      [1:0] o_idle,
   output logic            o_ss_rate
);
   // a load is only seen when probed, so the result lags the plug
   initial o_term = 2'h0;
   always @(posedge i_clk) begin
      if (i_pulse) o_term <= {2{i_present}};
   end
   assign o_idle = {2{i_idle}};
   assign o_ss_rate = !i_idle;
endmodule

// ---- verif/redriver_config_and_eq_control_bench.sv ----
// self-checking bench for the redriver control top
`timescale 1ns/1ps
module redriver_config_and_eq_control_bench;
   logic        clk = 1'h0;
   logic        rstn, int_n, present, idle, ss, bias, mode, pulse, rterm, ready;
   logic [1:0]  bus_en, term, eidle, link;
   logic [2:0]  lfps, en;
   logic [3:0]  rxs, sss, s1, s2, s3;
   logic [11:0] gain;
   logic [14:0] exp_q[$], a;
   int          error_cnt = 0, checked = 0;
   event        ev;
   rcq_top #(.HOLD_CYC_P(8), .RXDET_CYC_P(16)) dut (.i_clk(clk), .i_rstn(rstn),
      .i_int_reset_n(int_n), .i_cfg_bus_en_strap(bus_en), .i_rx_port_eq_straps(rxs),
      .i_sys_tx_eq_straps(sss), .i_rx_port_one_eq_setting(s1), .i_rx_port_two_eq_setting(s2),
      .i_sys_tx_eq_setting(s3), .i_lfps_det(lfps), .i_far_term_det(term), .i_elec_idle(eidle),
      .i_ss_rate(ss), .o_strap_bias_en(bias), .o_reg_mode(mode), .o_eq_gain(gain),
      .o_eq_en(en), .o_rx_det_pulse(pulse), .o_rx_term_en(rterm), .o_fwd_ready(ready),
      .o_link_state(link));
   rcq_far_end far (.i_clk(clk), .i_pulse(pulse), .i_present(present), .i_idle(idle),
      .o_term(term), .o_idle(eidle), .o_ss_rate(ss));
   initial forever #2.5 clk = ~clk;
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task put(input logic [14:0] e);
      exp_q.push_back(e);
      -> ev;
   endtask
   task chk(input logic [1:0] got, input logic [1:0] want);
      checked++;
      if (got !== want) begin
         error_cnt++;
         $display("CHECK FAILED %0t status %h not %h", $time, got, want);
      end
   endtask
   task wait_link(input logic [1:0] s);
      repeat (100) if (link !== s) cyc(1);
      chk(link, s);
   endtask
   task final_report;
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========
   // watcher: oldest note against the equalizer outputs
   initial forever begin
      @(ev);
      checked++;
      if ({en, gain} !== exp_q.pop_front()) begin
         error_cnt++;
         $display("CHECK FAILED %0t equalizer %h", $time, {en, gain});
      end
   end
   // whole run is under a thousand cycles
   initial begin
      #20000;
      error_cnt++;
      final_report();
   end
   initial begin
      void'($urandom(60825));
      {rstn, bus_en, lfps, present, idle, s1, s2, s3} = 20'h0;
      int_n = 1'h1;
      {rxs, sss} = 8'($urandom);
      cyc(5);
      rstn = 1'h1;
      cyc(4);
      a = {3'h7, sss, rxs, rxs};
      put(a);
      chk({1'h0, mode}, 2'h0);
      {rxs, sss} = ~{rxs, sss};
      cyc(3);
      put(a);
      for (int i = 0; i < 3; i++) begin
         lfps = 3'h1 << i;
         cyc(3);
         put({~lfps, a[11:0]});
      end
      lfps = 3'h0;
      chk({1'h0, bias}, 2'h0);
      present = 1'h1;
      wait_link(2'h1);
      chk({rterm, ready}, 2'h3);
      idle = 1'h1;
      wait_link(2'h3);
      lfps = 3'h4;
      wait_link(2'h1);
      {lfps, idle} = 4'h0;
      cyc(3);
      chk(link, 2'h1);
      idle = 1'h1;
      wait_link(2'h3);
      present = 1'h0;
      wait_link(2'h0);
      for (int l = 1; l < 4; l++) begin
         bus_en = 2'(l);
         {s1, s2, s3} = 12'($urandom);
         int_n = 1'h0;
         cyc(1);
         int_n = 1'h1;
         cyc(4);
         chk({1'h0, mode}, 2'h1);
         put({3'h7, s3, s2, s1});
      end
      rstn = 1'h0;
      cyc(1);
      chk({1'h0, bias}, 2'h1);
      final_report();
   end
endmodule
